// ---- core/sync_mon_pkg.sv ----
// package of constants for the two-channel synchronization monitor
// assumes a 10 MHz core clock; sensor and reset pins are asynchronous
package sync_mon_pkg;
    // difference counter width (quarter increments, signed)
    localparam int DIFF_W           = 16;
    // reset pulse least duration and its cycle count
    localparam int CLK_HZ           = 10_000_000;
    localparam int RST_MIN_MS       = 80;
    localparam int RST_MIN_CYC      = (CLK_HZ / 1000) * RST_MIN_MS;
    // led flash half period
    localparam int FLASH_HALF_MS    = 250;
    localparam int FLASH_HALF_CYC   = (CLK_HZ / 1000) * FLASH_HALF_MS;
    // default limit in quarter increments (50 increments)
    localparam logic [DIFF_W-1:0] LIMIT_DEFAULT = 16'h00C8;
endpackage

// ---- core/quad_chan.sv ----
// quadrature decoder for one sensor channel
// assumes phase inputs already synchronised to core_clk
module quad_chan
    import sync_mon_pkg::*;
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic arst_n,
    input  wire logic clk_en,
    // synchronised phases
    input  wire logic ph_a,
    input  wire logic ph_b,
    // decoded outputs
    output logic      freq_out,
    output logic      dbl_out,
    output logic      dir_fwd,
    output logic      step,
    output logic      step_up
);
    logic a_q;
    logic b_q;
    // edge and direction decoding
    wire edge_a = ph_a ^ a_q;
    wire edge_b = ph_b ^ b_q;
    wire any_e  = edge_a | edge_b;
    // forward when a leads b
    wire up     = edge_a ? (ph_a ^ ph_b) : ~(ph_a ^ ph_b);

    // registered phase and outputs
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            a_q      <= 1'b0;
            b_q      <= 1'b0;
            freq_out <= 1'b0;
            dbl_out  <= 1'b0;
            dir_fwd  <= 1'b1;
            step     <= 1'b0;
            step_up  <= 1'b0;
        end else if (clk_en) begin
            a_q      <= ph_a;
            b_q      <= ph_b;
            freq_out <= ph_a;
            dbl_out  <= ph_a ^ ph_b;
            if (any_e) begin
                dir_fwd <= up;
            end
            step     <= any_e;
            step_up  <= up;
        end
    end
endmodule

// ---- core/sync_mon.sv ----
// status, reset and output logic of the synchronization monitor
// assumes sensor pins, fault pins and the reset pin are asynchronous
module sync_mon
    import sync_mon_pkg::*;
#(
    parameter int          RST_CYC   = RST_MIN_CYC,
    parameter int          FLASH_CYC = FLASH_HALF_CYC
)
(
    // clock, reset, enable
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    input  wire logic              clk_en,
    // sensor phases, channel 1 and 2
    input  wire logic [1:0]        ph_a,
    input  wire logic [1:0]        ph_b,
    // sensor line faults and internal errors
    input  wire logic [1:0]        sensor_fault,
    input  wire logic              sw_error,
    input  wire logic              low_supply,
    // configuration
    input  wire logic              reset_in,
    input  wire logic              mode_strap,
    input  wire logic              fault_store,
    input  wire logic [DIFF_W-1:0] limit,
    // per channel pulse outputs
    output logic [1:0]             freq_out,
    output logic [1:0]             dbl_out,
    output logic [1:0]             dir_fwd,
    // relays, high means energized
    output logic                   relay_reset_req,
    output logic                   relay_prewarn,
    output logic                   relay_sync_fault,
    output logic                   relay_sensor,
    // leds
    output logic                   led_operation,
    output logic                   led_prewarn,
    output logic                   led_sync_fault,
    output logic                   led_sensor
);
    // two-stage synchronisers for all pins except limit, clk_en and arst_n, static straps included
    localparam int NS = 11;
    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    wire  [NS-1:0] raw = {ph_a, ph_b, sensor_fault, sw_error,
                          low_supply, fault_store, mode_strap, reset_in};
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1 <= '0;
            s2 <= '0;
        end else if (clk_en) begin
            s1 <= raw;
            s2 <= s1;
        end
    end
    wire [1:0] sa      = s2[10:9];
    wire [1:0] sb      = s2[8:7];
    wire       sens_f  = |s2[6:5];
    wire       int_err = s2[4] | s2[3];
    wire       store   = s2[2];                         // fault storage
    wire       rst_act = s2[0] ^ s2[1];

    // channel decoders
    logic [1:0] fo;
    logic [1:0] dbo;
    logic [1:0] dro;
    logic [1:0] stp;
    logic [1:0] sup;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : ch
            quad_chan u_ch (
                .core_clk (core_clk),
                .arst_n   (arst_n),
                .clk_en   (clk_en),
                .ph_a     (sa[g]),
                .ph_b     (sb[g]),
                .freq_out (fo[g]),
                .dbl_out  (dbo[g]),
                .dir_fwd  (dro[g]),
                .step     (stp[g]),
                .step_up  (sup[g])
            );
        end
    endgenerate

    // reset pulse width: accepted only after the least hold time
    logic [31:0] rst_cnt;
    logic        rst_ok;
    wire         rst_release = rst_ok & ~rst_act;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_cnt <= '0;
            rst_ok  <= 1'b0;
        end else if (clk_en) begin
            if (!rst_act) begin
                rst_cnt <= '0;
                rst_ok  <= 1'b0;
            end else if (rst_cnt >= 32'(RST_CYC - 1)) begin
                rst_ok  <= 1'b1;
            end else begin
                rst_cnt <= rst_cnt + 32'd1;
            end
        end
    end

    // decoder warm-up: synchronisers and edge detectors start at zero,
    // so a pin already high at release would count as a false edge
    logic [3:0] warm;
    wire        warm_done = warm[3];
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            warm <= '0;
        end else if (clk_en) begin
            warm <= {warm[2:0], 1'b1};
        end
    end

    // signed difference counter, channel 1 minus channel 2
    logic signed [DIFF_W-1:0] diff;
    wire signed [DIFF_W-1:0] d1 = stp[0] ? (sup[0] ? 16'sh0001 : -16'sh0001)
                                         : 16'sh0000;
    wire signed [DIFF_W-1:0] d2 = stp[1] ? (sup[1] ? 16'sh0001 : -16'sh0001)
                                         : 16'sh0000;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            diff <= '0;
        end else if (clk_en) begin
            if (rst_act | ~warm_done) begin
                diff <= '0;
            end else begin
                diff <= diff + d1 - d2;
            end
        end
    end
    wire [DIFF_W-1:0] mag     = diff[DIFF_W-1] ? DIFF_W'(-diff)
                                               : DIFF_W'(diff);
    wire              over_pw = mag > {1'b0, limit[DIFF_W-1:1]};
    wire              over_sf = mag > limit;

    // latched status: pending reset, stored sensor and sync faults
    logic pend;
    logic sens_mem;
    logic sync_mem;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pend     <= 1'b1;
            sens_mem <= 1'b0;
            sync_mem <= 1'b0;
        end else if (clk_en) begin
            // fault events win over a release in the same cycle
            if (int_err | sens_f | (store & over_sf)) begin
                pend <= 1'b1;
            end else if (rst_release) begin
                pend <= 1'b0;
            end
            if (sens_f) begin
                sens_mem <= 1'b1;
            end else if (rst_release) begin
                sens_mem <= 1'b0;
            end
            if (store & over_sf) begin
                sync_mem <= 1'b1;
            end else if (rst_release) begin
                sync_mem <= 1'b0;
            end
        end
    end

    // flash timebase
    logic [31:0] fl_cnt;
    logic        flash;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fl_cnt <= '0;
            flash  <= 1'b0;
        end else if (clk_en) begin
            if (fl_cnt >= 32'(FLASH_CYC - 1)) begin
                fl_cnt <= '0;
                flash  <= ~flash;
            end else begin
                fl_cnt <= fl_cnt + 32'd1;
            end
        end
    end

    // next output values
    wire req_off     = pend | rst_act;
    wire sync_f      = over_sf | sync_mem;
    wire next_rr     = ~req_off & ~sens_f;
    wire next_pw     = ~over_pw & ~sens_f;
    wire next_sf     = ~sync_f & ~sens_f;
    wire next_rs     = ~sens_f & ~sens_mem;
    wire next_lop    = req_off ? flash : 1'b1;
    wire next_lsens  = sens_f | (sens_mem & flash);

    // registered outputs
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            freq_out         <= '0;
            dbl_out          <= '0;
            dir_fwd          <= 2'h3;
            relay_reset_req  <= 1'b0;
            relay_prewarn    <= 1'b0;
            relay_sync_fault <= 1'b0;
            relay_sensor     <= 1'b0;
            led_operation    <= 1'b0;
            led_prewarn      <= 1'b0;
            led_sync_fault   <= 1'b0;
            led_sensor       <= 1'b0;
        end else if (clk_en) begin
            freq_out         <= fo;
            dbl_out          <= dbo;
            dir_fwd          <= dro;
            relay_reset_req  <= next_rr;
            relay_prewarn    <= next_pw;
            relay_sync_fault <= next_sf;
            relay_sensor     <= next_rs;
            led_operation    <= next_lop;
            led_prewarn      <= over_pw;
            led_sync_fault   <= sync_f;
            led_sensor       <= next_lsens;
        end
    end
endmodule

// ---- bench/quad_src.sv ----
// quadrature sensor model, one phase edge per request
// assumes the bench spaces requests evenly for a 1:1 duty
module quad_src
(
    // clock and request
    input  wire logic core_clk,
    input  wire logic go,
    input  wire logic fwd,
    // sensor phases
    output logic      ph_a,
    output logic      ph_b
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] pos = 2'h0;
    // gray walk, phase a leads phase b when turning forward
    always @(posedge core_clk) if (go) pos <= fwd ? pos + 2'h1 : pos - 2'h1;
    assign ph_a = (pos == 2'h1) || (pos == 2'h2);
    assign ph_b = pos[1];
endmodule

// ---- bench/sync_mon_props.sv ----
// port assertions for the synchronization monitor
// assumes clk_en drops only while pins stay still; bound into sync_mon
module sync_mon_props
    import sync_mon_pkg::*;
#(
    parameter int FLASH_CYC = FLASH_HALF_CYC
)
(
    // clock and reset
    input wire logic       core_clk, arst_n,
    // pins and pulse outputs
    input wire logic [1:0] ph_a, ph_b, sensor_fault, freq_out, dbl_out,
    input wire logic       sw_error, low_supply, reset_in, mode_strap,
    // relays and leds
    input wire logic       relay_reset_req, relay_prewarn,
    input wire logic       relay_sync_fault, relay_sensor,
    input wire logic       led_operation, led_prewarn,
    input wire logic       led_sync_fault, led_sensor
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    wire logic       act;
    wire logic [1:0] ab;
    int unsigned     still;
    logic [2:0]      since_rst;
    // active reset level and expected doubled pulse
    assign act = reset_in ^ mode_strap;
    assign ab = ph_a ^ ph_b;
    // cycles the operation led sat still while request is off
    always_ff @(posedge core_clk or negedge arst_n)
        if (!arst_n) still <= 0;
        else if (relay_reset_req || $changed(led_operation)) still <= 0;
        else still <= still + 1;
    // edges since reset release, saturating; the pulse path needs four
    always_ff @(posedge core_clk or negedge arst_n)
        if (!arst_n) since_rst <= '0;
        else if (since_rst != 3'h7) since_rst <= since_rst + 3'h1;
    pulse_follow_a: assert property (since_rst >= 3'h4 |->
        freq_out == $past(ph_a, 4) && dbl_out == $past(ab, 4))
        else $error("pulse outputs lag phases wrongly");
    power_up_a: assert property ($rose(arst_n) |->
        (!relay_reset_req) [*8]) else $error("request on after power up");
    reset_hold_a: assert property (act [*5] |-> !relay_reset_req)
        else $error("request on while reset held");
    error_req_a: assert property ((sw_error || low_supply) [*5]
        |-> !relay_reset_req) else $error("request on during error");
    op_flash_a: assert property (still <= FLASH_CYC + 2)
        else $error("operation led not flashing");
    op_steady_a: assert property (relay_reset_req && !led_prewarn
        && !led_sync_fault |-> led_operation) else $error("op led off");
    prewarn_pair_a: assert property (led_prewarn |-> !relay_prewarn)
        else $error("prewarn led and relay disagree");
    sync_pair_a: assert property (led_sync_fault |-> !relay_sync_fault)
        else $error("sync fault led and relay disagree");
    all_relays_a: assert property ((|sensor_fault) [*5] |-> !(relay_sensor
        || relay_reset_req || relay_prewarn || relay_sync_fault))
        else $error("relay on during sensor fault");
    sensor_led_a: assert property ((|sensor_fault) [*5] |-> led_sensor)
        else $error("sensor led dark during fault");
endmodule
bind sync_mon sync_mon_props #(.FLASH_CYC(FLASH_CYC)) u_props (.*);

// ---- bench/sync_mon_test.sv ----
// self-checking bench for the synchronization monitor
// assumes package, sensor model and bound checker compiled first
module sync_mon_test
    import sync_mon_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int RC = 20;
    localparam int FC = 4;
    logic             core_clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1;
    wire  [1:0]       ph_a, ph_b;
    logic [1:0]       go = 2'h0, fwd = 2'h3, sensor_fault = 2'h0;
    logic             sw_error = 1'b0, low_supply = 1'b0, reset_in = 1'b0;
    logic             mode_strap = 1'b0, fault_store = 1'b0;
    logic [DIFF_W-1:0] limit = 16'h0008;
    logic [1:0]       freq_out, dbl_out, dir_fwd, fl;
    logic             relay_reset_req, relay_prewarn, relay_sync_fault;
    logic             relay_sensor, led_operation, led_prewarn;
    logic             led_sync_fault, led_sensor;
    int               n_mismatch = 0, samples_checked = 0, cyc = 0;
    sync_mon #(.RST_CYC(RC), .FLASH_CYC(FC)) u_dut (.*);
    for (genvar c = 0; c < 2; c++) begin : g_src
        quad_src u_src (.core_clk(core_clk), .go(go[c]), .fwd(fwd[c]),
                        .ph_a(ph_a[c]), .ph_b(ph_b[c]));
    end
    initial forever #50 core_clk = ~core_clk;
    // hang guard
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_mismatch++;
            test_done();
        end
    end
    task automatic test_done();
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #5;
    endtask
    task automatic chk(input string what, input logic [4:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // operator reset held for len cycles, then released
    task automatic rst(input int len);
        reset_in = !mode_strap;
        tick(len);
        reset_in = mode_strap;
        tick(8);
    endtask
    // n phase edges on one channel, evenly spaced
    task automatic step(input int ch, input logic d, input int n);
        fwd[ch] = d;
        repeat (n) begin
            go[ch] = 1'b1;
            tick(1);
            go[ch] = 1'b0;
            tick(3);
        end
        tick(4);
    endtask
    initial begin
        tick(16);
        arst_n = 1'b1;
        tick(4);
        chk("request", relay_reset_req, 0);
        rst(RC / 2);
        chk("short reset", relay_reset_req, 0);
        rst(RC + 4);
        chk("healthy", {relay_reset_req, led_operation}, 2'h3);
        chk("relays", {relay_prewarn, relay_sync_fault}, 2'h3);
        for (int i = 1; i <= 9; i++) begin
            step(0, 1'b1, 1);
            chk("prewarn", {led_prewarn, relay_prewarn}, i > 4 ? 2 : 1);
            chk("sync", {led_sync_fault, relay_sync_fault}, i > 8 ? 2 : 1);
        end
        chk("pulses ch1", {freq_out[0], dbl_out[0], dir_fwd[0]}, 3'h7);
        step(1, 1'b1, 9);
        chk("recover", {led_prewarn, led_sync_fault, relay_sync_fault}, 1);
        step(1, 1'b0, 1);
        chk("dir ch2", dir_fwd[1], 0);
        step(0, 1'b1, 5);
        clk_en = 1'b0;
        limit = 16'h0010;
        tick(4);
        chk("freeze", {led_prewarn, relay_prewarn}, 2'h2);
        clk_en = 1'b1;
        tick(1);
        chk("wide limit", {led_prewarn, relay_prewarn}, 2'h1);
        limit = 16'h0008;
        rst(RC + 4);
        chk("cleared", {led_prewarn, relay_reset_req}, 2'h1);
        fault_store = 1'b1;
        step(0, 1'b1, 9);
        step(1, 1'b1, 9);
        chk("stored", {led_sync_fault, relay_reset_req}, 2'h2);
        rst(RC + 4);
        chk("stored clr", {led_sync_fault, relay_reset_req}, 2'h1);
        fault_store = 1'b0;
        sensor_fault = 2'h2;
        tick(8);
        chk("sensor on", {relay_reset_req, relay_prewarn, relay_sync_fault,
            relay_sensor, led_sensor}, 5'h01);
        sensor_fault = 2'h0;
        tick(8);
        chk("sensor off", {relay_sensor, relay_reset_req}, 0);
        fl = {led_operation, led_sensor};
        tick(FC);
        chk("flash", {led_operation, led_sensor}, fl ^ 2'h3);
        rst(RC + 4);
        chk("sensor rec", {relay_sensor, relay_reset_req, led_sensor}, 6);
        for (int k = 0; k < 2; k++) begin
            {sw_error, low_supply} = k ? 2'h1 : 2'h2;
            tick(8);
            chk("error", relay_reset_req, 0);
            {sw_error, low_supply} = 2'h0;
            rst(RC + 4);
            chk("error rec", relay_reset_req, 1);
        end
        {mode_strap, reset_in} = 2'h3;
        tick(8);
        chk("strap idle", relay_reset_req, 1);
        rst(RC + 4);
        chk("strap rst", relay_reset_req, 1);
        arst_n = 1'b0;
        tick(2);
        arst_n = 1'b1;
        tick(4);
        chk("power again", relay_reset_req, 0);
        test_done();
    end
endmodule
